// ==== core/health_query_pkg.sv ====
// constants shared by both ends of the health-report general command link
// assumes one clock at 50 MHz and a synchronous active-low reset
package health_query_pkg;
	// argument fields
	localparam int ARG_W = 32;
	localparam int DIR_BIT = 0;
	localparam int IDX_LSB = 1;
	localparam int IDX_W = 7;
	localparam int FARG1_LSB = 8;
	localparam int FARG2_LSB = 16;
	localparam int FARG3_LSB = 24;
	localparam logic [6:0] IDX_RETRIEVE = 7'h10;
	localparam logic [6:0] IDX_PRELOAD = 7'h08;
	// report sector
	localparam int SECTOR_BYTES = 512;
	localparam logic [8:0] LAST_BYTE = 9'h1ff;
	localparam int OFS_DIE_ID = 0;
	localparam int OFS_CTRL_REV = 9;
	localparam int OFS_FW_REV = 11;
	localparam int OFS_CE_COUNT = 14;
	localparam int OFS_BB_REPLACE_MAX = 16;
	localparam int OFS_BB_TABLE = 32;
	localparam int OFS_GOOD_PCT = 64;
	localparam int OFS_ERASE_TOTAL = 80;
	localparam int OFS_LIFE_PCT = 96;
	localparam int OFS_ERASE_LOW = 98;
	localparam int OFS_ERASE_HIGH = 104;
	localparam int OFS_POWER_UP = 112;
	localparam int OFS_ABN_OFF = 128;
	localparam int OFS_REFRESH = 160;
	localparam int OFS_MARKER = 176;
	localparam int OFS_BB_TABLE2 = 184;
	localparam int OFS_RESERVED = 216;
	localparam int STAT_W = 8 * OFS_RESERVED;
	// command response status
	localparam logic [1:0] RSP_OK = 2'h0;
	localparam logic [1:0] RSP_BAD_INDEX = 2'h1;
	localparam logic [1:0] RSP_NO_PRELOAD = 2'h2;
	localparam logic [1:0] RSP_BAD_ARG = 2'h3;
endpackage

// ==== core/health_query_if.sv ====
// command, response and data stream between host end and card end
// assumes both ends share i_mclk
`timescale 1ns/100ps
interface health_query_if;
	logic cmd_valid;
	logic [31:0] cmd_arg;
	logic cmd_ready;
	logic rsp_valid;
	logic [1:0] rsp_status;
	logic dat_valid;
	logic [7:0] dat_byte;
	logic dat_last;
	logic dat_ready;
	modport card (input cmd_valid, cmd_arg, dat_ready,
		output cmd_ready, rsp_valid, rsp_status, dat_valid, dat_byte, dat_last);
	modport host (output cmd_valid, cmd_arg, dat_ready,
		input cmd_ready, rsp_valid, rsp_status, dat_valid, dat_byte, dat_last);
endinterface

// ==== core/health_arg_decode.sv ====
// splits a general command argument into direction, index and three bytes
// pure combinational, used by the card end
`timescale 1ns/100ps
module health_arg_decode (
	// argument in
	input wire logic [31:0] i_arg,
	// fields out
	output logic o_read,
	output logic [6:0] o_index,
	output logic [7:0] o_farg1,
	output logic [7:0] o_farg2,
	output logic [7:0] o_farg3,
	output logic o_upper_clear
);
	assign o_read = i_arg[health_query_pkg::DIR_BIT]; // [R01]
	assign o_index = i_arg[health_query_pkg::IDX_LSB +: health_query_pkg::IDX_W]; // [R02]
	assign o_farg1 = i_arg[health_query_pkg::FARG1_LSB +: 8]; // [R05]
	assign o_farg2 = i_arg[health_query_pkg::FARG2_LSB +: 8]; // [R05]
	assign o_farg3 = i_arg[health_query_pkg::FARG3_LSB +: 8]; // [R05]
	assign o_upper_clear = (i_arg[31:8] == 24'h000000); // [R07] [R08]
endmodule

// ==== core/health_card.sv ====
// card end: answers health-report general commands
// assumes a host on the interface and live statistics on the user ports
// Notes on behaviour
// (R01) argument bit 0: one read, zero write
// (R02) bits 7..1 choose the function index
// (R03) read index 10h fetches prepared report
// (R04) write index 08h pre-loads the report
// (R05) bytes 1..3 are function arguments
// (R06) host pre-loads before it retrieves
// (R07) pre-load: upper bits zero, no data
// (R08) retrieve: bits 8..31 zero, 512 bytes
// (R09) identifier, revisions, chip-enable count placed
// (R10) bad-block max, table, good percentage placed
// (R11) erase total and remaining life placed
// (R12) erase statistics low words then high
// (R13) power-up, abnormal-off, refresh counts placed
// (R14) marker and second table; rest reserved
// (R15) reserved zero; data from last pre-load
// (R16) unknown index or no pre-load: error
`timescale 1ns/100ps
module health_card (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// link
	health_query_if.card bus,
	// live statistics
	input wire logic [71:0] i_memory_die_identifier,
	input wire logic [15:0] i_controller_revision,
	input wire logic [15:0] i_firmware_revision,
	input wire logic [7:0] i_ce_count,
	input wire logic [15:0] i_bb_replace_max,
	input wire logic [255:0] i_bb_table,
	input wire logic [15:0] i_good_pct,
	input wire logic [31:0] i_erase_total,
	input wire logic [15:0] i_life_pct,
	input wire logic [47:0] i_erase_low,
	input wire logic [47:0] i_erase_high,
	input wire logic [31:0] i_power_up_count,
	input wire logic [15:0] i_abn_off_count,
	input wire logic [15:0] i_refresh_count,
	input wire logic [63:0] i_marker,
	input wire logic [255:0] i_bb_table2,
	// status
	output logic o_busy,
	output logic [7:0] o_last_farg1,
	output logic [7:0] o_last_farg2,
	output logic [7:0] o_last_farg3
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RESP = 2'h1,
		ST_SEND = 2'h3
	} card_state_t;

	localparam int SW = health_query_pkg::STAT_W;

	card_state_t state_ff, nxt_state;
	logic [SW-1:0] snap_ff, nxt_snap;
	logic loaded_ff, nxt_loaded;
	logic [8:0] cnt_ff, nxt_cnt;
	logic [1:0] status_ff, nxt_status;
	logic send_ff, nxt_send;
	logic [7:0] byte_ff, nxt_byte;
	logic [23:0] farg_ff, nxt_farg;
	logic [SW-1:0] live;

	logic d_read;
	logic [6:0] d_index;
	logic [7:0] d_farg1;
	logic [7:0] d_farg2;
	logic [7:0] d_farg3;
	logic d_clear;

	health_arg_decode u_dec (
		.i_arg(bus.cmd_arg),
		.o_read(d_read),
		.o_index(d_index),
		.o_farg1(d_farg1),
		.o_farg2(d_farg2),
		.o_farg3(d_farg3),
		.o_upper_clear(d_clear)
	);

	// byte at sector position, zero past the used area
	function automatic logic [7:0] sector_byte(input logic [SW-1:0] img, input logic [8:0] pos);
		logic [7:0] b;
		b = 8'h00;
		if (pos < 9'(health_query_pkg::OFS_RESERVED)) begin
			b = img[8*pos +: 8];
		end
		return b;
	endfunction

	// ****************************************
	// report image layout
	// ****************************************
	always_comb begin
		live = '0;
		live[8*health_query_pkg::OFS_DIE_ID +: 72] = i_memory_die_identifier; // [R09]
		live[8*health_query_pkg::OFS_CTRL_REV +: 16] = i_controller_revision; // [R09]
		live[8*health_query_pkg::OFS_FW_REV +: 16] = i_firmware_revision; // [R09]
		live[8*health_query_pkg::OFS_CE_COUNT +: 8] = i_ce_count; // [R09]
		live[8*health_query_pkg::OFS_BB_REPLACE_MAX +: 16] = i_bb_replace_max; // [R10]
		live[8*health_query_pkg::OFS_BB_TABLE +: 256] = i_bb_table; // [R10]
		live[8*health_query_pkg::OFS_GOOD_PCT +: 16] = i_good_pct; // [R10]
		live[8*health_query_pkg::OFS_ERASE_TOTAL +: 32] = i_erase_total; // [R11]
		live[8*health_query_pkg::OFS_LIFE_PCT +: 16] = i_life_pct; // [R11]
		live[8*health_query_pkg::OFS_ERASE_LOW +: 48] = i_erase_low; // [R12]
		live[8*health_query_pkg::OFS_ERASE_HIGH +: 48] = i_erase_high; // [R12]
		live[8*health_query_pkg::OFS_POWER_UP +: 32] = i_power_up_count; // [R13]
		live[8*health_query_pkg::OFS_ABN_OFF +: 16] = i_abn_off_count; // [R13]
		live[8*health_query_pkg::OFS_REFRESH +: 16] = i_refresh_count; // [R13]
		live[8*health_query_pkg::OFS_MARKER +: 64] = i_marker; // [R14]
		live[8*health_query_pkg::OFS_BB_TABLE2 +: 256] = i_bb_table2; // [R14]
	end

	// ****************************************
	// command handling
	// ****************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_snap = snap_ff;
		nxt_loaded = loaded_ff;
		nxt_cnt = cnt_ff;
		nxt_status = status_ff;
		nxt_send = send_ff;
		nxt_byte = byte_ff;
		nxt_farg = farg_ff;
		case (state_ff)
			ST_IDLE: begin
				if (bus.cmd_valid) begin
					nxt_farg = {d_farg3, d_farg2, d_farg1};
					nxt_send = 1'b0;
					nxt_state = ST_RESP;
					if (!d_read && d_index == health_query_pkg::IDX_PRELOAD) begin // [R04]
						if (d_clear) begin // [R07]
							nxt_snap = live; // [R15]
							nxt_loaded = 1'b1;
							nxt_status = health_query_pkg::RSP_OK;
						end else begin
							nxt_status = health_query_pkg::RSP_BAD_ARG;
						end
					end else if (d_read && d_index == health_query_pkg::IDX_RETRIEVE) begin // [R03]
						if (!loaded_ff) begin // [R06] [R16]
							nxt_status = health_query_pkg::RSP_NO_PRELOAD;
						end else if (!d_clear) begin // [R08]
							nxt_status = health_query_pkg::RSP_BAD_ARG;
						end else begin
							nxt_status = health_query_pkg::RSP_OK;
							nxt_send = 1'b1;
							nxt_cnt = 9'h000;
							nxt_byte = sector_byte(snap_ff, 9'h000);
						end
					end else begin
						nxt_status = health_query_pkg::RSP_BAD_INDEX; // [R16]
					end
				end
			end
			ST_RESP: begin
				nxt_state = send_ff ? ST_SEND : ST_IDLE; // [R07]
			end
			ST_SEND: begin
				if (bus.dat_ready) begin
					if (cnt_ff == health_query_pkg::LAST_BYTE) begin // [R08]
						nxt_state = ST_IDLE;
						nxt_send = 1'b0;
					end else begin
						nxt_cnt = cnt_ff + 9'h001;
						nxt_byte = sector_byte(snap_ff, cnt_ff + 9'h001); // [R15]
					end
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_ff <= ST_IDLE;
			snap_ff <= '0;
			loaded_ff <= 1'b0;
			cnt_ff <= 9'h000;
			status_ff <= health_query_pkg::RSP_OK;
			send_ff <= 1'b0;
			byte_ff <= 8'h00;
			farg_ff <= 24'h000000;
		end else begin
			state_ff <= nxt_state;
			snap_ff <= nxt_snap;
			loaded_ff <= nxt_loaded;
			cnt_ff <= nxt_cnt;
			status_ff <= nxt_status;
			send_ff <= nxt_send;
			byte_ff <= nxt_byte;
			farg_ff <= nxt_farg;
		end
	end

	assign bus.cmd_ready = (state_ff == ST_IDLE);
	assign bus.rsp_valid = (state_ff == ST_RESP);
	assign bus.rsp_status = status_ff;
	assign bus.dat_valid = (state_ff == ST_SEND);
	assign bus.dat_byte = byte_ff;
	assign bus.dat_last = (state_ff == ST_SEND) && (cnt_ff == health_query_pkg::LAST_BYTE);
	assign o_busy = (state_ff != ST_IDLE);
	assign o_last_farg1 = farg_ff[7:0];
	assign o_last_farg2 = farg_ff[15:8];
	assign o_last_farg3 = farg_ff[23:16];
endmodule

// ==== core/health_host.sv ====
// host end: runs pre-load then retrieval and stores the sector
// assumes a card end on the interface
`timescale 1ns/100ps
module health_host (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// link
	health_query_if.host bus,
	// user request
	input wire logic i_start,
	input wire logic [8:0] i_rd_addr,
	// user result
	output logic o_done,
	output logic o_error,
	output logic [1:0] o_status,
	output logic [7:0] o_rd_data
);
	typedef enum logic [2:0] {
		HS_IDLE = 3'h0,
		HS_PRE = 3'h1,
		HS_PRE_RSP = 3'h3,
		HS_GET = 3'h2,
		HS_GET_RSP = 3'h6,
		HS_DATA = 3'h7
	} host_state_t;

	logic [7:0] sector_mem [0:health_query_pkg::SECTOR_BYTES-1];
	host_state_t state_ff, nxt_state;
	logic done_ff, nxt_done;
	logic err_ff, nxt_err;
	logic [1:0] stat_ff, nxt_stat;
	logic [8:0] wptr_ff, nxt_wptr;
	logic [7:0] rd_ff;

	// argument builder: reserved upper bits always zero
	function automatic logic [31:0] make_arg(input logic rd, input logic [6:0] idx);
		return {24'h000000, idx, rd};
	endfunction

	always_comb begin
		nxt_state = state_ff;
		nxt_done = 1'b0;
		nxt_err = err_ff;
		nxt_stat = stat_ff;
		nxt_wptr = wptr_ff;
		case (state_ff)
			HS_IDLE: if (i_start) begin
				nxt_state = HS_PRE; // [R06]
				nxt_err = 1'b0;
			end
			HS_PRE: if (bus.cmd_ready) nxt_state = HS_PRE_RSP;
			HS_PRE_RSP: if (bus.rsp_valid) begin
				nxt_stat = bus.rsp_status;
				if (bus.rsp_status == health_query_pkg::RSP_OK) begin
					nxt_state = HS_GET; // [R06]
				end else begin
					nxt_err = 1'b1;
					nxt_done = 1'b1;
					nxt_state = HS_IDLE;
				end
			end
			HS_GET: if (bus.cmd_ready) nxt_state = HS_GET_RSP;
			HS_GET_RSP: if (bus.rsp_valid) begin
				nxt_stat = bus.rsp_status;
				nxt_wptr = 9'h000;
				if (bus.rsp_status == health_query_pkg::RSP_OK) begin
					nxt_state = HS_DATA;
				end else begin
					nxt_err = 1'b1;
					nxt_done = 1'b1;
					nxt_state = HS_IDLE;
				end
			end
			HS_DATA: if (bus.dat_valid) begin
				nxt_wptr = wptr_ff + 9'h001;
				if (bus.dat_last) begin // [R08]
					nxt_done = 1'b1;
					nxt_state = HS_IDLE;
				end
			end
			default: nxt_state = HS_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_ff <= HS_IDLE;
			done_ff <= 1'b0;
			err_ff <= 1'b0;
			stat_ff <= health_query_pkg::RSP_OK;
			wptr_ff <= 9'h000;
		end else begin
			state_ff <= nxt_state;
			done_ff <= nxt_done;
			err_ff <= nxt_err;
			stat_ff <= nxt_stat;
			wptr_ff <= nxt_wptr;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (state_ff == HS_DATA && bus.dat_valid) begin
			sector_mem[wptr_ff] <= bus.dat_byte;
		end
		if (!i_rst_n) begin
			rd_ff <= 8'h00;
		end else begin
			rd_ff <= sector_mem[i_rd_addr];
		end
	end

	assign bus.cmd_valid = (state_ff == HS_PRE) || (state_ff == HS_GET);
	assign bus.cmd_arg = (state_ff == HS_GET) ?
		make_arg(1'b1, health_query_pkg::IDX_RETRIEVE) : // [R01] [R08]
		make_arg(1'b0, health_query_pkg::IDX_PRELOAD); // [R01] [R07]
	assign bus.dat_ready = (state_ff == HS_DATA);
	assign o_done = done_ff;
	assign o_error = err_ff;
	assign o_status = stat_ff;
	assign o_rd_data = rd_ff;
endmodule

// ==== dv/health_query_monitor.sv ====
// checker for the link between the host end and the card end
// assumes the plain link signals on one clock with a sync active-low reset
`timescale 1ns/100ps
module health_query_monitor (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// link
	input wire logic cmd_valid,
	input wire logic [31:0] cmd_arg,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [1:0] rsp_status,
	input wire logic dat_valid,
	input wire logic [7:0] dat_byte,
	input wire logic dat_last,
	input wire logic dat_ready
);
	// ****************
	// byte position
	// ****************
	logic [8:0] cnt_ff;
	logic [8:0] nxt_cnt;
	logic take;
	assign take = cmd_valid && cmd_ready;
	always_comb begin
		nxt_cnt = cnt_ff;
		if (dat_valid && dat_ready)
			nxt_cnt = dat_last ? 9'h000 : cnt_ff + 9'h001;
	end
	always_ff @(posedge i_mclk) begin
		cnt_ff <= i_rst_n ? nxt_cnt : 9'h000;
	end
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	a_rsp_after_take: assert property (take |=> rsp_valid && !cmd_ready)
		else $error("no response one cycle after command");
	a_rsp_single: assert property (rsp_valid |=> !rsp_valid)
		else $error("response longer than one cycle");
	a_status_hold: assert property (!rsp_valid |=> rsp_valid || $stable(rsp_status))
		else $error("status changed without response");
	a_preload_no_data: assert property (take && cmd_arg == 32'h00000010 |=>
		rsp_status == health_query_pkg::RSP_OK ##1 (cmd_ready && !dat_valid))
		else $error("preload not accepted or sent data");
	a_retrieve_gives_data: assert property ((take && cmd_arg == 32'h00000021) ##1
		(rsp_status == health_query_pkg::RSP_OK) |=> dat_valid)
		else $error("retrieve ok without data");
	a_sector_length: assert property (dat_valid |-> dat_last == (cnt_ff == 9'h1ff))
		else $error("last flag not on byte 511");
	a_last_release: assert property (dat_valid && dat_ready && dat_last |=>
		!dat_valid && cmd_ready)
		else $error("card not idle after last byte");
	a_idle_quiet: assert property (cmd_ready |-> !dat_valid)
		else $error("data while idle");
	c_preload: cover property (take && cmd_arg == 32'h00000010);
	c_retrieve: cover property (take && cmd_arg == 32'h00000021);
	c_last: cover property (dat_valid && dat_ready && dat_last);
endmodule

// ==== dv/test_smart_health_query.sv ====
// bench: host end against card end, plus a bench-driven second card end
// assumes the design files under core/ are compiled first
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module test_smart_health_query;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_start = 1'b0;
	logic [8:0] i_rd_addr = 9'h000;
	logic o_done, o_error, busy_b;
	logic [1:0] o_status;
	logic [7:0] o_rd_data, farg1, farg2, farg3;
	logic [71:0] i_memory_die_identifier;
	logic [15:0] i_controller_revision, i_firmware_revision, i_bb_replace_max, i_good_pct;
	logic [15:0] i_life_pct, i_abn_off_count, i_refresh_count;
	logic [7:0] i_ce_count;
	logic [255:0] i_bb_table, i_bb_table2;
	logic [31:0] i_erase_total, i_power_up_count, fa;
	logic [47:0] i_erase_low, i_erase_high;
	logic [63:0] i_marker;
	logic [7:0] snap [0:511];
	int num_errors = 0;
	int total_checks = 0;
	int seed = 48379;
	int cycles = 0;
	always #10 i_mclk = ~i_mclk;
	health_query_if link_a ();
	health_query_if link_b ();
	health_host health_host_inst (.i_mclk, .i_rst_n, .bus(link_a), .i_start, .i_rd_addr,
		.o_done, .o_error, .o_status, .o_rd_data);
	health_card health_card_inst (.i_mclk, .i_rst_n, .bus(link_a), .i_memory_die_identifier,
		.i_controller_revision, .i_firmware_revision, .i_ce_count, .i_bb_replace_max,
		.i_bb_table, .i_good_pct, .i_erase_total, .i_life_pct, .i_erase_low, .i_erase_high,
		.i_power_up_count, .i_abn_off_count, .i_refresh_count, .i_marker, .i_bb_table2,
		.o_busy(), .o_last_farg1(), .o_last_farg2(), .o_last_farg3());
	health_card health_card_inst_b (.i_mclk, .i_rst_n, .bus(link_b), .i_memory_die_identifier,
		.i_controller_revision, .i_firmware_revision, .i_ce_count, .i_bb_replace_max,
		.i_bb_table, .i_good_pct, .i_erase_total, .i_life_pct, .i_erase_low, .i_erase_high,
		.i_power_up_count, .i_abn_off_count, .i_refresh_count, .i_marker, .i_bb_table2,
		.o_busy(busy_b), .o_last_farg1(farg1), .o_last_farg2(farg2), .o_last_farg3(farg3));
	health_query_monitor health_query_monitor_inst (.i_mclk, .i_rst_n,
		.cmd_valid(link_a.cmd_valid), .cmd_arg(link_a.cmd_arg), .cmd_ready(link_a.cmd_ready),
		.rsp_valid(link_a.rsp_valid), .rsp_status(link_a.rsp_status),
		.dat_valid(link_a.dat_valid), .dat_byte(link_a.dat_byte),
		.dat_last(link_a.dat_last), .dat_ready(link_a.dat_ready));
	// ****************
	// expectations
	// ****************
	function automatic bit in(int a, int lo, int hi);
		return a >= lo && a <= hi;
	endfunction
	function automatic logic [7:0] exp_byte(int a);
		if (in(a, 0, 8)) return i_memory_die_identifier[8*a +: 8];
		if (in(a, 9, 10)) return i_controller_revision[8*(a-9) +: 8];
		if (in(a, 11, 12)) return i_firmware_revision[8*(a-11) +: 8];
		if (a == 14) return i_ce_count;
		if (in(a, 16, 17)) return i_bb_replace_max[8*(a-16) +: 8];
		if (in(a, 32, 63)) return i_bb_table[8*(a-32) +: 8];
		if (in(a, 64, 65)) return i_good_pct[8*(a-64) +: 8];
		if (in(a, 80, 83)) return i_erase_total[8*(a-80) +: 8];
		if (in(a, 96, 97)) return i_life_pct[8*(a-96) +: 8];
		if (in(a, 98, 103)) return i_erase_low[8*(a-98) +: 8];
		if (in(a, 104, 109)) return i_erase_high[8*(a-104) +: 8];
		if (in(a, 112, 115)) return i_power_up_count[8*(a-112) +: 8];
		if (in(a, 128, 129)) return i_abn_off_count[8*(a-128) +: 8];
		if (in(a, 160, 161)) return i_refresh_count[8*(a-160) +: 8];
		if (in(a, 176, 183)) return i_marker[8*(a-176) +: 8];
		if (in(a, 184, 215)) return i_bb_table2[8*(a-184) +: 8];
		return 8'h00;
	endfunction
	// ****************
	// drivers
	// ****************
	task automatic step();
		@(posedge i_mclk);
		#1;
	endtask
	task automatic rand_stats();
		logic [1023:0] r;
		for (int k = 0; k < 32; k++) r[32*k +: 32] = $random(seed);
		{i_memory_die_identifier, i_controller_revision, i_firmware_revision, i_ce_count,
			i_bb_replace_max, i_bb_table, i_good_pct, i_erase_total, i_life_pct, i_erase_low,
			i_erase_high, i_power_up_count, i_abn_off_count, i_refresh_count, i_marker,
			i_bb_table2} = r[927:0];
	endtask
	task automatic take_snap();
		for (int a = 0; a < 512; a++) snap[a] = exp_byte(a);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic host_run();
		int g;
		g = 0;
		rand_stats();
		take_snap();
		step();
		i_start = 1'b1;
		step();
		i_start = 1'b0;
		while (o_done !== 1'b1 && g < 3000) begin
			step();
			g++;
		end
		`CHK("done", 1'b1, o_done)
		`CHK("error", 1'b0, o_error)
		`CHK("status", health_query_pkg::RSP_OK, o_status)
		for (int a = 0; a < 512; a++) begin
			i_rd_addr = a[8:0];
			step();
			`CHK("host_byte", snap[a], o_rd_data)
		end
	endtask
	task automatic cmd_b(input logic [31:0] arg, input logic [1:0] st);
		int g;
		g = 0;
		step();
		link_b.cmd_valid = 1'b1;
		link_b.cmd_arg = arg;
		while (link_b.cmd_ready !== 1'b1 && g < 100) begin
			step();
			g++;
		end
		step();
		link_b.cmd_valid = 1'b0;
		`CHK("rsp_valid", 1'b1, link_b.rsp_valid)
		`CHK("rsp_status", st, link_b.rsp_status)
	endtask
	task automatic collect_b();
		int n;
		int g;
		n = 0;
		g = 0;
		while (n < 512 && g < 4000) begin
			link_b.dat_ready = ($random(seed) & 3) != 0;
			if (link_b.dat_valid === 1'b1 && link_b.dat_ready === 1'b1) begin
				`CHK("dat_byte", snap[n], link_b.dat_byte)
				`CHK("dat_last", n == 511, link_b.dat_last)
				n++;
			end
			step();
			g++;
		end
		link_b.dat_ready = 1'b0;
		`CHK("sector_bytes", 512, n)
		`CHK("idle_ready", 1'b1, link_b.cmd_ready)
		`CHK("idle_busy", 1'b0, busy_b)
	endtask
	// ****************
	// sequence
	// ****************
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		link_b.cmd_valid = 1'b0;
		link_b.cmd_arg = 32'h00000000;
		link_b.dat_ready = 1'b0;
		rand_stats();
		repeat (6) @(posedge i_mclk);
		#1;
		i_rst_n = 1'b1;
		host_run();
		host_run();
		cmd_b(32'h00000021, health_query_pkg::RSP_NO_PRELOAD);
		for (int k = 0; k < 4; k++) begin
			fa = $random(seed);
			cmd_b({fa[23:0], 7'h55, 1'b0}, health_query_pkg::RSP_BAD_INDEX);
			`CHK("farg1", fa[7:0], farg1)
			`CHK("farg2", fa[15:8], farg2)
			`CHK("farg3", fa[23:16], farg3)
		end
		cmd_b(32'h00000020, health_query_pkg::RSP_BAD_INDEX);
		cmd_b(32'h00000011, health_query_pkg::RSP_BAD_INDEX);
		take_snap();
		cmd_b(32'h00000010, health_query_pkg::RSP_OK);
		rand_stats();
		cmd_b(32'h00ab0010, health_query_pkg::RSP_BAD_ARG);
		cmd_b(32'h00000021, health_query_pkg::RSP_OK);
		collect_b();
		cmd_b(32'h00008021, health_query_pkg::RSP_BAD_ARG);
		cmd_b(32'h00000021, health_query_pkg::RSP_OK);
		collect_b();
		report_and_stop();
	end
endmodule
